// ---- design/usm_pkg.sv ----
package usm_pkg;

    // Word indices; the byte address is four times the index.
    localparam logic [5:0] IDX_STATUS = 6'h00;
    localparam logic [5:0] IDX_RXDATA = 6'h01;
    localparam logic [5:0] IDX_TXDATA = 6'h02;
    localparam logic [5:0] IDX_BAUD = 6'h03;
    localparam logic [5:0] IDX_MATCH = 6'h04;
    localparam logic [5:0] IDX_MODE = 6'h05;

    // Status and control field positions.
    localparam int STA_TXSEL1 = 15;
    localparam int STA_INV = 14;
    localparam int STA_TXSEL0 = 13;
    localparam int STA_BRK = 11;
    localparam int STA_TXEN = 10;
    localparam int STA_TXBF = 9;
    localparam int STA_TX_ALL_EMPTY = 8;
    localparam int STA_RXSEL1 = 7;
    localparam int STA_RXSEL0 = 6;
    localparam int STA_ADDRESS_DETECT_ENABLE = 5;
    localparam int STA_RECEIVER_IDLE = 4;
    localparam int STA_PARITY_ERROR = 3;
    localparam int STA_FRAMING_ERROR = 2;
    localparam int STA_OVERRUN_ERROR = 1;
    localparam int STA_RXDA = 0;

    // Mode field positions.
    localparam int MODE_EN = 15;
    localparam int MODE_IR = 12;
    localparam int MODE_HS = 3;
    localparam int MODE_PD1 = 2;
    localparam int MODE_PD0 = 1;
    localparam int MODE_ST = 0;

    localparam int ADDR_FLAG = 8;
    localparam int WORD_W = 9;

    localparam logic [4:0] TICKS_STD = 5'h10;
    localparam logic [4:0] TICKS_HIGH = 5'h04;
    localparam logic [2:0] QUEUE_DEPTH = 3'h4;
    localparam logic [2:0] RX_THREE = 3'h3;
    localparam logic [3:0] DATA_BITS_8 = 4'h8;
    localparam logic [3:0] DATA_BITS_9 = 4'h9;
    localparam logic [3:0] BREAK_LEN = 4'hE;
    localparam logic [13:0] BREAK_FRAME = 14'h2000;

    localparam logic [1:0] TXI_EACH = 2'h0;
    localparam logic [1:0] TXI_DONE = 2'h1;
    localparam logic [1:0] TXI_EMPTY = 2'h2;
    localparam logic [1:0] RXI_THREE = 2'h2;
    localparam logic [1:0] RXI_FULL = 2'h3;

    localparam logic [1:0] PD_NONE8 = 2'h0;
    localparam logic [1:0] PD_EVEN = 2'h1;
    localparam logic [1:0] PD_ODD = 2'h2;
    localparam logic [1:0] PD_NINE = 2'h3;

    typedef struct packed {
        logic port_enable;
        logic infrared_codec_enable;
        logic high_speed_select;
        logic [1:0] parity_data_select;
        logic stop_count_select;
    } usm_mode_type;

    typedef struct packed {
        logic parity_error;
        logic framing_error;
        logic [8:0] word;
    } usm_rx_entry_type;

    typedef struct packed {
        logic [3:0] len;
        logic [13:0] bits;
    } usm_frame_type;

    typedef enum logic [2:0] {
        RX_IDLE = 3'b001,
        RX_START = 3'b010,
        RX_DATA = 3'b100
    } usm_rx_state_type;

endpackage

// ---- design/usm_uart.sv ----
// Overview of operation
// [R1] Select 10: interrupt when load empties buffer
// [R2] Select 01: interrupt when all transmission done
// [R3] Select 00: interrupt on every load; 11 reserved
// [R4] Polarity bit sets idle level, codec-dependent
// [R5] Break: start, twelve zeros, stop; self-clearing
// [R6] Transmit disable aborts, flushes, releases pin
// [R7] Buffer full flag when no room left
// [R8] Transmit idle flag: shifter and buffer empty
// [R9] Receive select 11: interrupt on fourth character
// [R10] Receive select 10: interrupt on third character
// [R11] Receive select 0x: interrupt every character
// [R12] Address detect acts only in 9-bit mode
// [R13] Receiver idle flag, reset one
// [R14] Parity error follows receive head entry
// [R15] Framing error follows receive head entry
// [R16] Overrun on overflow; clearing flushes receiver
// [R17] Data available while receive buffer nonempty
// [R18] Receive word in bits 8-0, upper zero
// [R19] Transmit word in bits 8-0, upper zero
// [R20] Sixteen-bit divisor, reset zero, sets rate
// [R21] Mask bits select compared address bits
// [R22] Low byte holds address compared in hardware
// [R23] Sixteen ticks per bit, four in high speed
// [R24] Parity/data select: 9N, 8O, 8E, 8N
// [R25] Stop select: two stop bits or one
// [R26] Break started by dummy write, value ignored
// [R27] Frame: start, data LSB first, parity, stops
//
// The placing of the registers and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module usm_uart (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rx_i,
    output logic tx_o,
    output logic tx_oe_o,
    output logic tx_irq_o,
    output logic rx_irq_o
);

    function automatic logic parity_bit(input logic [7:0] d, input logic [1:0] pd);
        parity_bit = (^d) ^ (pd == usm_pkg::PD_ODD);
    endfunction

    function automatic logic has_parity(input logic [1:0] pd);
        has_parity = (pd == usm_pkg::PD_EVEN) || (pd == usm_pkg::PD_ODD);
    endfunction

    function automatic logic [3:0] data_bits(input logic [1:0] pd);
        data_bits = (pd == usm_pkg::PD_NINE) ? usm_pkg::DATA_BITS_9 : usm_pkg::DATA_BITS_8;
    endfunction

    function automatic usm_pkg::usm_frame_type build_frame(
        input logic [8:0] d, input usm_pkg::usm_mode_type m, input logic brk);
        logic [3:0] nd;
        logic [13:0] f;
        nd = data_bits(m.parity_data_select);
        f = '1;
        f[0] = 1'b0;
        for (int i = 0; i < usm_pkg::WORD_W; i++)
        begin
            if (i < int'(nd))
                f[i + 1] = d[i];
        end
        if (has_parity(m.parity_data_select))
            f[nd + 4'h1] = parity_bit(d[7:0], m.parity_data_select);
        build_frame.bits = f;
        build_frame.len = 4'h2 + nd + {3'h0, has_parity(m.parity_data_select)}
            + {3'h0, m.stop_count_select};
        if (brk)
        begin
            build_frame.bits = usm_pkg::BREAK_FRAME;
            build_frame.len = usm_pkg::BREAK_LEN;
        end
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old,
        input logic [15:0] nw, input logic [1:0] sel);
        merge16[7:0] = sel[0] ? nw[7:0] : old[7:0];
        merge16[15:8] = sel[1] ? nw[15:8] : old[15:8];
    endfunction

    logic ack_r;
    logic [31:0] dat_r;
    logic [1:0] tx_sel_r;
    logic inv_r;
    logic brk_r;
    logic txen_r;
    logic txen_prev_r;
    logic [1:0] rx_sel_r;
    logic address_detect_enable_r;
    logic overrun_error_r;
    usm_pkg::usm_mode_type mode_r;
    logic [15:0] baud_r;
    logic [15:0] match_r;
    logic [15:0] brg_cnt_r;
    logic tick_r;
    logic [8:0] txq_r [0:3];
    logic [1:0] txq_wp_r;
    logic [1:0] txq_rp_r;
    logic [2:0] txq_cnt_r;
    logic [13:0] tsr_r;
    logic [3:0] tx_len_r;
    logic [4:0] tx_sub_r;
    logic tx_busy_r;
    logic brk_frame_r;
    logic tx_r;
    logic oe_r;
    logic tx_irq_r;
    usm_pkg::usm_rx_state_type rx_state_r;
    logic [4:0] rx_sub_r;
    logic [3:0] rx_idx_r;
    logic [9:0] rx_sh_r;
    logic addr_open_r;
    usm_pkg::usm_rx_entry_type rxq_r [0:3];
    logic [1:0] rxq_wp_r;
    logic [1:0] rxq_rp_r;
    logic [2:0] rxq_cnt_r;
    logic rx_irq_r;

    logic bus_hit;
    logic [5:0] idx;
    logic wr;
    logic rd;
    logic wr_sta;
    logic [15:0] sta;
    logic [4:0] bit_last;
    logic [4:0] half_last;
    logic tx_flush;
    logic tx_load;
    logic tx_push;
    logic tx_bit_end;
    logic tx_done;
    usm_pkg::usm_frame_type frame;
    logic rx_bit_end;
    logic rx_finish;
    logic [3:0] stop_idx;
    usm_pkg::usm_rx_entry_type fin;
    logic addr_hit;
    logic accept;
    logic rx_push;
    logic rx_pop;
    logic overrun_error_set;
    logic overrun_error_clear;
    usm_pkg::usm_rx_entry_type head;

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign tx_o = tx_r;
    assign tx_oe_o = oe_r;
    assign tx_irq_o = tx_irq_r;
    assign rx_irq_o = rx_irq_r;

    always_comb
    begin
        bus_hit = wb_cyc_i & wb_stb_i & ~ack_r;
        idx = wb_adr_i[7:2];
        wr = bus_hit & wb_we_i;
        rd = bus_hit & ~wb_we_i;
        wr_sta = wr & (idx == usm_pkg::IDX_STATUS);
        bit_last = (mode_r.high_speed_select ? usm_pkg::TICKS_HIGH
            : usm_pkg::TICKS_STD) - 5'h01; // see [R23]
        half_last = {1'b0, bit_last[4:1]};
        head = rxq_r[rxq_rp_r];
        sta = 16'h0000;
        sta[usm_pkg::STA_TXSEL1] = tx_sel_r[1];
        sta[usm_pkg::STA_INV] = inv_r;
        sta[usm_pkg::STA_TXSEL0] = tx_sel_r[0];
        sta[usm_pkg::STA_BRK] = brk_r;
        sta[usm_pkg::STA_TXEN] = txen_r;
        sta[usm_pkg::STA_TXBF] = (txq_cnt_r == usm_pkg::QUEUE_DEPTH); // see [R7]
        sta[usm_pkg::STA_TX_ALL_EMPTY] = ~tx_busy_r & (txq_cnt_r == 3'h0); // see [R8]
        sta[usm_pkg::STA_RXSEL1] = rx_sel_r[1];
        sta[usm_pkg::STA_RXSEL0] = rx_sel_r[0];
        sta[usm_pkg::STA_ADDRESS_DETECT_ENABLE] = address_detect_enable_r;
        sta[usm_pkg::STA_RECEIVER_IDLE] = (rx_state_r == usm_pkg::RX_IDLE); // see [R13]
        sta[usm_pkg::STA_PARITY_ERROR] = (rxq_cnt_r != 3'h0) & head.parity_error; // see [R14]
        sta[usm_pkg::STA_FRAMING_ERROR] = (rxq_cnt_r != 3'h0) & head.framing_error; // see [R15]
        sta[usm_pkg::STA_OVERRUN_ERROR] = overrun_error_r;
        sta[usm_pkg::STA_RXDA] = (rxq_cnt_r != 3'h0); // see [R17]
    end

    // Registered answer: ack comes one edge after the request is seen.
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end
        else
        begin
            ack_r <= bus_hit;
            dat_r <= 32'h0000_0000;
            if (rd)
            begin
                unique case (idx)
                    usm_pkg::IDX_STATUS: dat_r[15:0] <= sta;
                    usm_pkg::IDX_RXDATA:
                        if (rxq_cnt_r != 3'h0)
                            dat_r[8:0] <= head.word; // see [R18]
                    usm_pkg::IDX_BAUD: dat_r[15:0] <= baud_r;
                    usm_pkg::IDX_MATCH: dat_r[15:0] <= match_r;
                    usm_pkg::IDX_MODE:
                    begin
                        dat_r[usm_pkg::MODE_EN] <= mode_r.port_enable;
                        dat_r[usm_pkg::MODE_IR] <= mode_r.infrared_codec_enable;
                        dat_r[usm_pkg::MODE_HS] <= mode_r.high_speed_select;
                        dat_r[usm_pkg::MODE_PD1:usm_pkg::MODE_PD0]
                            <= mode_r.parity_data_select;
                        dat_r[usm_pkg::MODE_ST] <= mode_r.stop_count_select;
                    end
                    default: dat_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Control fields of the status register.
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tx_sel_r <= 2'h0;
            inv_r <= 1'b0;
            brk_r <= 1'b0;
            txen_r <= 1'b0;
            txen_prev_r <= 1'b0;
            rx_sel_r <= 2'h0;
            address_detect_enable_r <= 1'b0;
        end
        else
        begin
            txen_prev_r <= txen_r;
            if (tx_done & brk_frame_r)
                brk_r <= 1'b0; // see [R5]
            if (wr_sta & wb_sel_i[1])
            begin
                tx_sel_r <= {wb_dat_i[usm_pkg::STA_TXSEL1], wb_dat_i[usm_pkg::STA_TXSEL0]};
                inv_r <= wb_dat_i[usm_pkg::STA_INV];
                brk_r <= wb_dat_i[usm_pkg::STA_BRK];
                txen_r <= wb_dat_i[usm_pkg::STA_TXEN];
            end
            if (wr_sta & wb_sel_i[0])
            begin
                rx_sel_r <= wb_dat_i[usm_pkg::STA_RXSEL1:usm_pkg::STA_RXSEL0];
                address_detect_enable_r <= wb_dat_i[usm_pkg::STA_ADDRESS_DETECT_ENABLE];
            end
        end
    end

    // Plain configuration registers.
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            baud_r <= 16'h0000;
            match_r <= 16'h0000;
            mode_r <= '0;
        end
        else if (wr)
        begin
            if (idx == usm_pkg::IDX_BAUD)
                baud_r <= merge16(baud_r, wb_dat_i[15:0], wb_sel_i[1:0]); // see [R20]
            if (idx == usm_pkg::IDX_MATCH)
                match_r <= merge16(match_r, wb_dat_i[15:0], wb_sel_i[1:0]); // see [R21] [R22]
            if (idx == usm_pkg::IDX_MODE)
            begin
                if (wb_sel_i[1])
                begin
                    mode_r.port_enable <= wb_dat_i[usm_pkg::MODE_EN];
                    mode_r.infrared_codec_enable <= wb_dat_i[usm_pkg::MODE_IR];
                end
                if (wb_sel_i[0])
                begin
                    mode_r.high_speed_select <= wb_dat_i[usm_pkg::MODE_HS];
                    mode_r.parity_data_select
                        <= wb_dat_i[usm_pkg::MODE_PD1:usm_pkg::MODE_PD0];
                    mode_r.stop_count_select <= wb_dat_i[usm_pkg::MODE_ST];
                end
            end
        end
    end

    // Generator ticks at clock/(divisor+1); held cleared while disabled.
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            brg_cnt_r <= 16'h0000;
            tick_r <= 1'b0;
        end
        else if (!mode_r.port_enable)
        begin
            brg_cnt_r <= 16'h0000;
            tick_r <= 1'b0;
        end
        else
        begin
            tick_r <= (brg_cnt_r == baud_r); // see [R20]
            brg_cnt_r <= (brg_cnt_r == baud_r) ? 16'h0000 : brg_cnt_r + 16'h0001;
        end
    end

    always_comb
    begin
        // Flushing on the falling edge of enable lets software preload
        // the buffer while transmit is off and start it by enabling.
        tx_flush = (txen_prev_r & ~txen_r) | ~mode_r.port_enable; // see [R6]
        tx_push = wr & (idx == usm_pkg::IDX_TXDATA) & wb_sel_i[0]
            & (txq_cnt_r != usm_pkg::QUEUE_DEPTH) & ~tx_flush; // see [R7] [R19]
        tx_load = ~tx_busy_r & (txq_cnt_r != 3'h0) & txen_r & ~tx_flush;
        frame = build_frame(txq_r[txq_rp_r], mode_r, brk_r); // see [R26]
        tx_bit_end = tx_busy_r & tick_r & (tx_sub_r == bit_last);
        tx_done = tx_bit_end & (tx_len_r == 4'h1);
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            txq_wp_r <= 2'h0;
            txq_rp_r <= 2'h0;
            txq_cnt_r <= 3'h0;
            for (int i = 0; i < 4; i++)
                txq_r[i] <= 9'h000;
        end
        else if (tx_flush)
        begin
            txq_wp_r <= 2'h0;
            txq_rp_r <= 2'h0;
            txq_cnt_r <= 3'h0; // see [R6]
        end
        else
        begin
            if (tx_push)
            begin
                txq_r[txq_wp_r] <= {wb_sel_i[1] & wb_dat_i[8], wb_dat_i[7:0]};
                txq_wp_r <= txq_wp_r + 2'h1;
            end
            if (tx_load)
                txq_rp_r <= txq_rp_r + 2'h1;
            txq_cnt_r <= txq_cnt_r + {2'h0, tx_push} - {2'h0, tx_load};
        end
    end

    // Transmit shifter; bit 0 of the frame goes out first.
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tsr_r <= '1;
            tx_len_r <= 4'h0;
            tx_sub_r <= 5'h00;
            tx_busy_r <= 1'b0;
            brk_frame_r <= 1'b0;
        end
        else if (tx_flush)
            tx_busy_r <= 1'b0; // see [R6]
        else if (tx_load)
        begin
            tsr_r <= frame.bits; // see [R27] [R24] [R25] [R5]
            tx_len_r <= frame.len;
            tx_sub_r <= 5'h00;
            tx_busy_r <= 1'b1;
            brk_frame_r <= brk_r;
        end
        else if (tx_busy_r & tick_r)
        begin
            tx_sub_r <= tx_bit_end ? 5'h00 : tx_sub_r + 5'h01;
            if (tx_bit_end)
            begin
                tsr_r <= {1'b1, tsr_r[13:1]};
                tx_len_r <= tx_len_r - 4'h1;
                if (tx_done)
                    tx_busy_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tx_r <= 1'b1;
            oe_r <= 1'b0;
            tx_irq_r <= 1'b0;
        end
        else
        begin
            // The codec reverses the sense of the polarity bit.
            tx_r <= (tx_busy_r ? tsr_r[0] : 1'b1)
                ^ (inv_r ^ mode_r.infrared_codec_enable); // see [R4]
            oe_r <= mode_r.port_enable & txen_r; // see [R6]
            unique case (tx_sel_r)
                usm_pkg::TXI_EACH: tx_irq_r <= tx_load; // see [R3]
                usm_pkg::TXI_EMPTY:
                    tx_irq_r <= tx_load & (txq_cnt_r == 3'h1) & ~tx_push; // see [R1]
                usm_pkg::TXI_DONE:
                    tx_irq_r <= tx_done & (txq_cnt_r == 3'h0); // see [R2]
                default: tx_irq_r <= 1'b0; // see [R3]
            endcase
        end
    end

    always_comb
    begin
        rx_bit_end = tick_r & (rx_sub_r == bit_last);
        stop_idx = data_bits(mode_r.parity_data_select)
            + {3'h0, has_parity(mode_r.parity_data_select)};
        rx_finish = (rx_state_r == usm_pkg::RX_DATA) & rx_bit_end & (rx_idx_r == stop_idx);
        fin.word = (mode_r.parity_data_select == usm_pkg::PD_NINE)
            ? rx_sh_r[usm_pkg::WORD_W - 1:0] : {1'b0, rx_sh_r[7:0]};
        fin.framing_error = ~rx_i; // see [R15]
        fin.parity_error = has_parity(mode_r.parity_data_select)
            & (rx_sh_r[usm_pkg::ADDR_FLAG]
            != parity_bit(rx_sh_r[7:0], mode_r.parity_data_select)); // see [R14]
        addr_hit = ((fin.word[7:0] ^ match_r[7:0]) & match_r[15:8]) == 8'h00; // see [R21] [R22]
        accept = 1'b1;
        if (address_detect_enable_r & (mode_r.parity_data_select == usm_pkg::PD_NINE)) // see [R12]
            accept = fin.word[usm_pkg::ADDR_FLAG] ? addr_hit : addr_open_r;
        overrun_error_set = rx_finish & accept & (rxq_cnt_r == usm_pkg::QUEUE_DEPTH); // see [R16]
        rx_push = rx_finish & accept & (rxq_cnt_r != usm_pkg::QUEUE_DEPTH);
        overrun_error_clear = wr_sta & wb_sel_i[0] & overrun_error_r & ~wb_dat_i[usm_pkg::STA_OVERRUN_ERROR]
            & ~overrun_error_set;
        rx_pop = rd & (idx == usm_pkg::IDX_RXDATA) & (rxq_cnt_r != 3'h0);
    end

    // Receiver: centre of start bit, then one sample per bit period.
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rx_state_r <= usm_pkg::RX_IDLE;
            rx_sub_r <= 5'h00;
            rx_idx_r <= 4'h0;
            rx_sh_r <= 10'h000;
            addr_open_r <= 1'b0;
        end
        else if (overrun_error_clear | ~mode_r.port_enable)
            rx_state_r <= usm_pkg::RX_IDLE; // see [R16]
        else if (tick_r)
        begin
            rx_sub_r <= rx_sub_r + 5'h01;
            unique case (rx_state_r)
                usm_pkg::RX_IDLE:
                begin
                    rx_sub_r <= 5'h00;
                    if (!rx_i)
                        rx_state_r <= usm_pkg::RX_START;
                end
                usm_pkg::RX_START:
                    if (rx_sub_r == half_last)
                    begin
                        rx_sub_r <= 5'h00;
                        rx_idx_r <= 4'h0;
                        rx_state_r <= rx_i ? usm_pkg::RX_IDLE : usm_pkg::RX_DATA;
                    end
                usm_pkg::RX_DATA:
                    if (rx_bit_end)
                    begin
                        rx_sub_r <= 5'h00;
                        rx_sh_r[rx_idx_r] <= rx_i;
                        rx_idx_r <= rx_idx_r + 4'h1;
                        if (rx_finish)
                        begin
                            rx_state_r <= usm_pkg::RX_IDLE;
                            if (address_detect_enable_r & fin.word[usm_pkg::ADDR_FLAG])
                                addr_open_r <= addr_hit; // see [R12]
                        end
                    end
                default: rx_state_r <= usm_pkg::RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rxq_wp_r <= 2'h0;
            rxq_rp_r <= 2'h0;
            rxq_cnt_r <= 3'h0;
            for (int i = 0; i < 4; i++)
                rxq_r[i] <= '0;
        end
        else if (overrun_error_clear)
        begin
            rxq_wp_r <= 2'h0;
            rxq_rp_r <= 2'h0;
            rxq_cnt_r <= 3'h0; // see [R16]
        end
        else
        begin
            if (rx_push)
            begin
                rxq_r[rxq_wp_r] <= fin;
                rxq_wp_r <= rxq_wp_r + 2'h1;
            end
            if (rx_pop)
                rxq_rp_r <= rxq_rp_r + 2'h1; // see [R14] [R15]
            rxq_cnt_r <= rxq_cnt_r + {2'h0, rx_push} - {2'h0, rx_pop};
        end
    end

    // The new overrun wins over a clear written in the same cycle.
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            overrun_error_r <= 1'b0;
            rx_irq_r <= 1'b0;
        end
        else
        begin
            if (overrun_error_set)
                overrun_error_r <= 1'b1; // see [R16]
            else if (overrun_error_clear)
                overrun_error_r <= 1'b0;
            unique case (rx_sel_r)
                usm_pkg::RXI_FULL:
                    rx_irq_r <= rx_push & (rxq_cnt_r + 3'h1 - {2'h0, rx_pop}
                        == usm_pkg::QUEUE_DEPTH); // see [R9]
                usm_pkg::RXI_THREE:
                    rx_irq_r <= rx_push & (rxq_cnt_r + 3'h1 - {2'h0, rx_pop}
                        == usm_pkg::RX_THREE); // see [R10]
                default: rx_irq_r <= rx_push; // see [R11]
            endcase
        end
    end

endmodule

`default_nettype wire

// ---- verif/usm_uart_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module usm_uart_sva (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic rx_i,
    input wire logic tx_o,
    input wire logic tx_oe_o,
    input wire logic tx_irq_o,
    input wire logic rx_irq_o
);
    wire logic rd = wb_ack_o && !wb_we_i;
    wire logic [5:0] idx = wb_adr_i[7:2];
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (rst_i);
    property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("no ack");
    property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack held");
    property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("data outside ack");
    property p_rx_upper; rd && idx == 6'h01 |-> wb_dat_o[31:9] == 23'h0; endproperty
    a_rx_upper: assert property (p_rx_upper) else $error("rx upper bits");
    property p_tx_upper; rd && idx == 6'h02 |-> wb_dat_o[31:9] == 23'h0; endproperty
    a_tx_upper: assert property (p_tx_upper) else $error("tx upper bits");
    property p_sta; rd && idx == 6'h00 |-> !(wb_dat_o[9] && wb_dat_o[8]); endproperty
    a_sta: assert property (p_sta) else $error("full and empty");
    property p_txi; tx_irq_o |=> !tx_irq_o; endproperty
    a_txi: assert property (p_txi) else $error("tx irq held");
    property p_rxi; rx_irq_o |=> !rx_irq_o; endproperty
    a_rxi: assert property (p_rxi) else $error("rx irq held");
    property p_oe; $changed(tx_oe_o) |-> $past(wb_cyc_i && wb_we_i); endproperty
    a_oe: assert property (p_oe) else $error("pin owner changed");
endmodule
bind usm_uart usm_uart_sva chk (.*);
`default_nettype wire

// ---- verif/usm_far_end.sv ----
`timescale 1ns/1ps
`default_nettype none
module usm_far_end (
    input wire logic clock_i,
    input wire logic tx_i,
    output logic rx_o
);
    localparam int BIT = 16;
    initial rx_o = 1'h1;
    task automatic send(input logic [7:0] d);
        logic [9:0] f;
        f = {1'h1, d, 1'h0};
        for (int i = 0; i < 11; i++)
        begin
            @(posedge clock_i);
            rx_o <= (i < 10) ? f[i] : 1'h1;
            repeat (BIT - 1) @(posedge clock_i);
        end
    endtask
    // Samples mid-bit so a one-cycle skew at the start edge is harmless.
    task automatic recv(output logic [7:0] d);
        while (tx_i !== 1'h0) @(negedge clock_i);
        repeat (BIT / 2) @(negedge clock_i);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT) @(negedge clock_i);
            d[i] = tx_i;
        end
    endtask
endmodule
`default_nettype wire

// ---- verif/usm_uart_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module usm_uart_test;
    logic clock_i, rst_i = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0;
    logic [7:0] adr = 8'h00, c;
    logic [31:0] wdat = 32'h0, q;
    wire logic [31:0] rdat;
    wire logic ack, tx, oe, txi, rxi, rx;
    int n_mismatch, check_count, cyc_count, n_txi, n_rxi, lo;
    typedef struct packed {logic [7:0] a; logic [15:0] d; logic [15:0] e;} usm_row_type;
    usm_row_type rows [4] = '{'{8'h0C, 16'hA5C3, 16'hA5C3}, '{8'h10, 16'hFF12, 16'hFF12},
        '{8'h18, 16'hFFFF, 16'h0000}, '{8'h0C, 16'h0000, 16'h0000}};
    usm_uart dut (.clock_i(clock_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .rx_i(rx), .tx_o(tx), .tx_oe_o(oe), .tx_irq_o(txi), .rx_irq_o(rxi));
    usm_far_end far (.clock_i(clock_i), .tx_i(tx), .rx_o(rx));
    initial
    begin
        clock_i = 1'h0;
        forever #12.5 clock_i = ~clock_i;
    end
    always @(posedge clock_i)
    begin
        cyc_count++;
        if (txi === 1'h1) n_txi++;
        if (rxi === 1'h1) n_rxi++;
        if (cyc_count == 5000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] e, input logic [31:0] g, input string s);
        check_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask
    // Read data is taken and the request released at the edge that finds ack high.
    task automatic bus(input logic [7:0] a, input logic w, input logic [15:0] d);
        @(posedge clock_i);
        {cyc, stb, we, adr, wdat} <= {2'h3, w, a, 16'h0000, d};
        do @(posedge clock_i); while (ack !== 1'h1);
        q = rdat;
        {cyc, stb} <= 2'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e, input string s);
        bus(a, 1'h0, 16'h0000);
        chk({16'h0000, e}, q, s);
    endtask
    initial
    begin
        repeat (5) @(posedge clock_i);
        rst_i <= 1'h0;
        rd(8'h00, 16'h0110, "status reset");
        rd(8'h04, 16'h0000, "rx reset");
        rd(8'h08, 16'h0000, "tx word");
        foreach (rows[i])
        begin
            bus(rows[i].a, 1'h1, rows[i].d);
            rd(rows[i].a, rows[i].e, "row");
        end
        bus(8'h14, 1'h1, 16'h8000);
        repeat (4) bus(8'h08, 1'h1, 16'h0155);
        rd(8'h00, 16'h0210, "full");
        bus(8'h00, 1'h1, 16'h0400);
        bus(8'h00, 1'h1, 16'h0000);
        rd(8'h00, 16'h0110, "flushed");
        chk(32'h0, {31'h0, oe}, "oe off");
        bus(8'h00, 1'h1, 16'h0400);
        lo = n_txi;
        bus(8'h08, 1'h1, 16'h0155);
        far.recv(c);
        chk(32'h55, {24'h0, c}, "tx char");
        chk(lo + 1, n_txi, "tx irq");
        bus(8'h00, 1'h1, 16'h0C00);
        bus(8'h08, 1'h1, 16'h00FF);
        // The last data bit of the previous frame is low; wait for its stop bit first.
        while (tx !== 1'h1) @(negedge clock_i);
        while (tx !== 1'h0) @(negedge clock_i);
        lo = 0;
        while (tx === 1'h0)
        begin
            @(negedge clock_i);
            lo++;
        end
        chk(208, lo, "break low");
        repeat (40) @(posedge clock_i);
        rd(8'h00, 16'h0510, "break done");
        chk(32'h1, {31'h0, oe}, "oe on");
        bus(8'h00, 1'h1, 16'h04C0);
        lo = n_rxi;
        for (int i = 1; i < 6; i++) far.send(8'h10 + i[7:0]);
        chk(lo + 1, n_rxi, "rx irq");
        rd(8'h00, 16'h05D3, "overrun");
        rd(8'h04, 16'h0011, "rx head");
        bus(8'h00, 1'h1, 16'h04C0);
        rd(8'h00, 16'h05D0, "cleared");
        end_of_test();
    end
endmodule
`default_nettype wire
